// ==== sim/tc_model.sv ====
// Traffic controller model answering after a chosen latency
`timescale 1ns/100ps

module tc_model
   import xlat_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Request side
   input  wire logic        tc_req_i,
   input  wire mem_req_type tc_cmd_i,
   input  wire logic [3:0]  lat_i,
   // Answer side
   output logic             tc_ack_o,
   output logic      [31:0] tc_rdata_o,
   output mem_req_type      last_o
);
   localparam logic [31:0] rd_word = 32'h45600F02;
   logic [3:0] cnt_q;

   // Wait lat_i cycles, then one ack pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !tc_req_i || tc_ack_o) begin
         cnt_q    <= 4'h0;
         tc_ack_o <= 1'b0;
      end else if (cnt_q == lat_i) begin
         tc_ack_o <= 1'b1;
         last_o   <= tc_cmd_i;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // Data valid only with ack, inverted otherwise
   assign tc_rdata_o = tc_ack_o ? rd_word : ~rd_word;
endmodule // tc_model

// ==== sim/xlat_unit_tb.sv ====
// Self-checking bench of the address translation unit
`timescale 1ns/100ps
`include "xlat_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end

module xlat_unit_tb
   import xlat_pkg::*;
;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, dreq = 0;
   logic        tc_ack, irq, wb_ack, dack, tc_req;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  lat = 4'h0;
   logic [31:0] dat = 32'h0, wb_dat_o, drdata, tc_rdata, r, drd;
   mem_req_type dcmd = '0, tc_cmd, last;
   int          n_fail = 0, n_checks = 0, nc, n1;

   xlat_unit xlat_unit_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack), .dsp_req_i(dreq), .dsp_cmd_i(dcmd), .dsp_ack_o(dack),
      .dsp_rdata_o(drdata), .tc_req_o(tc_req), .tc_cmd_o(tc_cmd), .tc_ack_i(tc_ack),
      .tc_rdata_i(tc_rdata), .translation_fault_interrupt_o(irq));
   tc_model tc_model_i (.clk_i(clk_i), .rst_i(rst_i), .tc_req_i(tc_req), .tc_cmd_i(tc_cmd),
      .lat_i(lat), .tc_ack_o(tc_ack), .tc_rdata_o(tc_rdata), .last_o(last));

   // Clock generator
   initial begin
      forever #4 clk_i = ~clk_i;
   end

   // Classic Wishbone single cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      r = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // Stage and commit one TLB entry
   task automatic ent(input logic [19:0] t, p, input logic [1:0] ap, input logic [3:0] i);
      wb(1'b1, `OFS_TAG_H, {16'h0, t[19:4]});
      wb(1'b1, `OFS_TAG_L, {16'h0, t[3:0], 12'h004});
      wb(1'b1, `OFS_XL_H, {16'h0, p[19:4]});
      wb(1'b1, `OFS_XL_L, {16'h0, p[3:0], 2'h0, ap, 8'h00});
      wb(1'b1, `OFS_LOCK, {28'h0, i});
      wb(1'b1, `OFS_TLBLD, 32'h1);
   endtask

   // Raise a DSP request
   task automatic dgo(input logic w, input logic [31:0] a);
      @(posedge clk_i);
      dreq <= 1'b1;
      dcmd <= '{w, a, 32'hA1B2C3D4};
   endtask

   // Wait for ack, or for a fault when fi is set
   task automatic dwait(input logic fi);
      nc = 0;
      do begin
         @(posedge clk_i);
         nc++;
      end while (dack !== 1'b1 && !(fi && irq === 1'b1) && nc < 400);
      `CHK("wait", 1'b1, nc < 400)
      if (dack === 1'b1) begin
         drd = drdata;
         dreq <= 1'b0;
      end
   endtask

   // Direct map after reset
   task automatic t_direct;
      wb(1'b0, `OFS_CLKCTL, 32'h0);
      `CHK("div", 32'h0, r)
      wb(1'b1, `OFS_CLKCTL, 32'h0);
      wb(1'b1, `OFS_CTRL, 32'h1);
      wb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, r)
      dgo(1'b0, 32'hAB123458);
      dwait(1'b0);
      n1 = nc;
      `CHK("direct", 32'h00123458, last.addr)
      `CHK("rdata", 32'h020F6045, drd)
      $display("done direct");
   endtask

   // Host-written entry translates a write
   task automatic t_xlat;
      ent(20'h00005, 20'h87654, 2'h3, 4'h0);
      wb(1'b1, `OFS_CTRL, 32'h3);
      lat <= 4'h5;
      dgo(1'b1, 32'h00005ABC);
      dwait(1'b0);
      `CHK("xaddr", 32'h87654ABC, last.addr)
      `CHK("xdata", 32'hD4C3B2A1, last.data)
      `CHK("xwe", 1'b1, last.we)
      $display("done xlat");
   endtask

   // Every permission code, then a write to a read-only page
   task automatic t_perm;
      for (int k = 0; k < 5; k++) begin
         ent(20'h00006, 20'h22222, (k == 4) ? 2'h2 : k[1:0], 4'h1);
         dgo(k == 4, 32'h00006010);
         dwait(1'b1);
         `CHK("fault", (k < 2 || k == 4), irq)
         if (irq === 1'b1) begin
            wb(1'b0, `OFS_FADDR_L, 32'h0);
            `CHK("faddr", 32'h6010, r)
            wb(1'b0, `OFS_FCAUSE, 32'h0);
            `CHK("cause", 1'b1, r[`CAUSE_PERM])
            ent(20'h00006, 20'h22222, 2'h3, 4'h1);
            `CHK("held", 1'b1, irq)
            wb(1'b1, `OFS_IACK, 32'h1);
            dwait(1'b0);
            `CHK("irqclr", 1'b0, irq)
         end
         `CHK("retry", 32'h22222010, last.addr)
      end
      $display("done perm");
   endtask

   // Walker locks base and fills a miss
   task automatic t_walk;
      wb(1'b1, `OFS_TBASE_L, 32'h1234);
      wb(1'b1, `OFS_CTRL, 32'h7);
      wb(1'b1, `OFS_TBASE_L, 32'h5678);
      wb(1'b0, `OFS_TBASE_L, 32'h0);
      `CHK("lock", 32'h1234, r)
      dgo(1'b0, 32'h00312340);
      dwait(1'b0);
      `CHK("walk", 32'h45612340, last.addr)
      $display("done walk");
   endtask

   // Divider, shutoff and autogating
   task automatic t_clock;
      lat <= 4'h0;
      wb(1'b1, `OFS_CLKCTL, 32'h3);
      dgo(1'b0, 32'h00005000);
      dwait(1'b0);
      `CHK("div8", 1'b1, nc > n1)
      wb(1'b1, `OFS_IDLE, 32'h1);
      dgo(1'b0, 32'h00005004);
      repeat (40) @(posedge clk_i);
      `CHK("shutoff", 1'b0, tc_req)
      `CHK("stopped", 32'h87654000, last.addr)
      wb(1'b1, `OFS_IDLE, 32'h2);
      dwait(1'b0);
      `CHK("autogate", 32'h87654004, last.addr)
      $display("done clock");
   endtask

   // Verdict and end of run
   task automatic finish_test;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_direct;
      t_xlat;
      t_perm;
      t_walk;
      t_clock;
      finish_test;
   end

   // Watchdog
   initial begin
      repeat (30000) @(posedge clk_i);
      n_fail++;
      finish_test;
   end
endmodule // xlat_unit_tb

// ==== src/tlb_store.sv ====
// Fully associative TLB with flush and one write port
`timescale 1ns/100ps
`include "xlat_params.svh"

module tlb_store
   import xlat_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Flush and write
   input  wire logic          flush_i,
   input  wire logic          wr_i,
   input  wire logic [3:0]    wr_idx_i,
   input  wire tlb_entry_type wr_entry_i,
   // Lookup
   input  wire logic [19:0]   tag_i,
   output logic               hit_o,
   output tlb_entry_type      hit_entry_o
);
   tlb_entry_type             mem_q [`TLB_DEPTH];
   logic [`TLB_DEPTH-1:0]     match;

   // Lowest matching index
   function automatic logic [3:0] first_set(input logic [`TLB_DEPTH-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = `TLB_DEPTH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // Tag compare for every entry
   for (genvar g = 0; g < `TLB_DEPTH; g++) begin : g_cmp
      assign match[g] = mem_q[g].valid && mem_q[g].tag == tag_i;
   end

   assign hit_o = |match;
   assign hit_entry_o = mem_q[first_set(match)];

   // Entry storage; flush wins over a write
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < `TLB_DEPTH; i++) begin
         if (rst_i || flush_i) begin
            mem_q[i].valid <= 1'b0;
            mem_q[i].keep <= 1'b0;
         end else if (wr_i && wr_idx_i == 4'(i)) begin
            mem_q[i] <= wr_entry_i;
         end
      end
   end

   property p_flush;
      @(posedge clk_i) disable iff (rst_i)
      flush_i |=> !hit_o;
   endproperty
   a_flush: assert property (p_flush) else $error("hit after flush");
endmodule // tlb_store

// ==== src/unit_clock_gen.sv ====
// Unit clock divider and gating, as a tick in the source clock domain
`timescale 1ns/100ps
`include "xlat_params.svh"

module unit_clock_gen
   import xlat_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Controls
   input  wire logic [1:0] div_sel_i,
   input  wire logic       shutoff_i,
   input  wire logic       autogate_i,
   input  wire logic       busy_i,
   // Unit clock tick
   output logic            tick_o
);
   logic [2:0] cnt_q;
   logic [2:0] limit;
   logic       run;

   // Terminal count for ratios 1, 2, 4, 8
   assign limit = 3'((4'h1 << div_sel_i) - 4'h1);
   // Stop on shutoff, or while idle with gating on
   assign run = !shutoff_i && (busy_i || !autogate_i);

   // Divider counter
   always_ff @(posedge clk_i) begin
      if (rst_i || !run || cnt_q >= limit) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   // One tick per unit clock period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= run && cnt_q >= limit;
      end
   end

   property p_div8_gap;
      @(posedge clk_i) disable iff (rst_i)
      tick_o && div_sel_i == 2'h3 && $stable(div_sel_i) |=> !tick_o [*7];
   endproperty
   a_div8_gap: assert property (p_div8_gap) else $error("tick too early at div 8");

   property p_shutoff;
      @(posedge clk_i) disable iff (rst_i)
      shutoff_i |=> !tick_o;
   endproperty
   a_shutoff: assert property (p_shutoff) else $error("tick while shut off");
endmodule // unit_clock_gen

// ==== src/xlat_params.svh ====
// Offsets, field positions, reset values and counts of the translation unit
// What this block does
// - Unit clock divided by 1, 2, 4, 8
// - Divider resets to divide by one
// - Global shutoff bit stops unit clock
// - Autogating stops clock only while idle
// - Walker enabled locks load, base, lock writes
// - One fault interrupt, cause in register
// - Fault interrupt is a held level
// - Accept DSP requests, compare tag with TLB
// - Hit with permission: translate, swap, forward
// - Walker off, miss or denial: fault, stall
// - After clear, redo whole lookup
// - Walker on, miss: fetch, load, then check
// - Denial after refill: fault and stall
// - Staged tag and page written at victim
// - Soft reset clears valid, keeps pointers
// - Hardware reset: direct map, no checks
// - Permission 0x, none; 10 read; 11 all
// - Fault captures faulting virtual address
`ifndef XLAT_PARAMS_SVH
`define XLAT_PARAMS_SVH
`define OFS_CTRL     8'h08
`define OFS_FADDR_H  8'h0C
`define OFS_FADDR_L  8'h10
`define OFS_FCAUSE   8'h14
`define OFS_IACK     8'h18
`define OFS_TBASE_H  8'h1C
`define OFS_TBASE_L  8'h20
`define OFS_LOCK     8'h24
`define OFS_TLBLD    8'h28
`define OFS_TAG_H    8'h2C
`define OFS_TAG_L    8'h30
`define OFS_XL_H     8'h34
`define OFS_XL_L     8'h38
`define OFS_IDLE     8'h54
`define OFS_CLKCTL   8'h58
`define CTL_RUN      0
`define CTL_XEN      1
`define CTL_WEN      2
`define IDLE_OFF     0
`define IDLE_AUTO    1
`define CAUSE_MISS   0
`define CAUSE_XFLT   1
`define CAUSE_PERM   2
`define TAG_V        2
`define TAG_P        3
`define XL_AP_HI     9
`define XL_AP_LO     8
`define LOCK_BASE_LO 8
`define DIV_RST      2'h0
`define AP_RW        2'h3
`define DIRECT_HI    8'h00
`define DESC_SECTION 2'h2
`define TLB_DEPTH    16
`define TLB_LAST     4'hF
`endif

// ==== src/xlat_pkg.sv ====
// Types shared by the translation unit modules
package xlat_pkg;
   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [31:0] data;
   } mem_req_type;
   typedef struct packed {
      logic        valid;
      logic        keep;
      logic [19:0] tag;
      logic [19:0] page;
      logic [1:0]  perm;
   } tlb_entry_type;
   typedef enum {st_idle, st_look, st_walk, st_fwd, st_fault} xlat_state_type;
endpackage

// ==== src/xlat_unit.sv ====
// DSP address translation unit: register slave, lookup, walker, fault
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`include "xlat_params.svh"

module xlat_unit
   import xlat_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone register slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // DSP memory port
   input  wire logic        dsp_req_i,
   input  wire mem_req_type dsp_cmd_i,
   output logic             dsp_ack_o,
   output logic      [31:0] dsp_rdata_o,
   // Traffic controller
   output logic             tc_req_o,
   output mem_req_type      tc_cmd_o,
   input  wire logic        tc_ack_i,
   input  wire logic [31:0] tc_rdata_i,
   // Host interrupt
   output logic             translation_fault_interrupt_o
);
   xlat_state_type          st_q;
   xlat_state_type          look_next;
   mem_req_type             va_q;
   tlb_entry_type           hit_entry;
   tlb_entry_type           walk_entry;
   tlb_entry_type           new_entry;
   logic [2:0]              ctrl_q;
   logic [1:0]              idle_q;
   logic [1:0]              div_q;
   logic [31:0]             tbase_q;
   logic [31:0]             tag_stage_q;
   logic [31:0]             xl_stage_q;
   logic [31:0]             fault_addr_q;
   logic [3:0]              vict_q;
   logic [3:0]              base_q;
   logic [2:0]              cause_q;
   logic                    tc_done_q;
   logic [31:0]             tc_data_q;
   logic [2:0]              fault_cause;
   logic [31:0]             phys;
   logic                    tick;
   logic                    hit;
   logic                    wr_acc;
   logic                    lock_ok;
   logic                    soft_rst;
   logic                    busy;
   logic                    host_tlb_wr;
   logic                    walk_tlb_wr;
   logic                    walk_bad;
   logic                    fault_set;
   logic                    iack_wr;
   logic                    fwd_done;

   // Byte order conversion toward the traffic controller
   function automatic logic [31:0] swap32(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

   // Byte-lane merge of a write into an old half word
   function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                         input logic [1:0] s);
      logic [15:0] r;
      r = o;
      for (int b = 0; b < 2; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Permission decode: 10 read only, 11 full, else none
   function automatic logic perm_ok(input logic [1:0] ap, input logic we);
      return we ? (ap == `AP_RW) : ap[1];
   endfunction

   // Bus strobes and state flags
   assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign lock_ok = !ctrl_q[`CTL_WEN];
   assign soft_rst = !ctrl_q[`CTL_RUN];
   assign iack_wr = wr_acc && wb_adr_i == `OFS_IACK && wb_sel_i[0] && wb_dat_i[0];
   assign busy = dsp_req_i || st_q != st_idle || tc_req_o;

   // TLB fill sources
   assign host_tlb_wr = wr_acc && wb_adr_i == `OFS_TLBLD && wb_sel_i[0] && wb_dat_i[0]
                        && lock_ok;
   assign walk_bad = tc_data_q[1:0] != `DESC_SECTION;
   assign walk_tlb_wr = tick && st_q == st_walk && tc_done_q && !walk_bad;
   assign walk_entry = '{valid: 1'b1, keep: 1'b0, tag: va_q.addr[31:12],
                         page: {tc_data_q[31:20], va_q.addr[19:12]},
                         perm: tc_data_q[`XL_AP_HI:`XL_AP_LO]};
   assign new_entry = host_tlb_wr ?
                      tlb_entry_type'{valid: tag_stage_q[`TAG_V], keep: tag_stage_q[`TAG_P],
                        tag: tag_stage_q[31:12], page: xl_stage_q[31:12],
                        perm: xl_stage_q[`XL_AP_HI:`XL_AP_LO]} : walk_entry;

   unit_clock_gen u_clk (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .div_sel_i  (div_q),
      .shutoff_i  (idle_q[`IDLE_OFF]),
      .autogate_i (idle_q[`IDLE_AUTO]),
      .busy_i     (busy),
      .tick_o     (tick)
   );

   tlb_store u_tlb (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .flush_i     (soft_rst),
      .wr_i        (host_tlb_wr || walk_tlb_wr),
      .wr_idx_i    (vict_q),
      .wr_entry_i  (new_entry),
      .tag_i       (va_q.addr[31:12]),
      .hit_o       (hit),
      .hit_entry_o (hit_entry)
   );

   // Lookup decision for the held request
   always_comb begin
      look_next = st_fault;
      fault_cause = 3'h0;
      phys = {`DIRECT_HI, va_q.addr[23:0]};
      if (!ctrl_q[`CTL_XEN]) begin
         look_next = st_fwd;
      end else if (hit && perm_ok(hit_entry.perm, va_q.we)) begin
         look_next = st_fwd;
         phys = {hit_entry.page, va_q.addr[11:0]};
      end else if (hit) begin
         fault_cause[`CAUSE_PERM] = 1'b1;
      end else if (ctrl_q[`CTL_WEN]) begin
         look_next = st_walk;
      end else begin
         fault_cause[`CAUSE_MISS] = 1'b1;
      end
   end

   assign fault_set = tick && ((st_q == st_look && look_next == st_fault)
                               || (st_q == st_walk && tc_done_q && walk_bad));
   assign fwd_done = tick && st_q == st_fwd && tc_done_q;

   // Translation state machine, stepped by the unit clock tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= st_idle;
         va_q <= '0;
      end else if (tick) begin
         case (st_q)
            st_idle: begin
               if (dsp_req_i && !dsp_ack_o) begin
                  va_q <= dsp_cmd_i;
                  st_q <= st_look;
               end
            end
            st_look: st_q <= look_next;
            st_walk: begin
               if (tc_done_q) begin
                  st_q <= walk_bad ? st_fault : st_look;
               end
            end
            st_fwd: begin
               if (tc_done_q) begin
                  st_q <= st_idle;
               end
            end
            st_fault: begin
               if (!translation_fault_interrupt_o) begin
                  st_q <= st_look;
               end
            end
            default: st_q <= st_idle;
         endcase
      end
   end

   // Traffic controller request, held until acknowledged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tc_req_o <= 1'b0;
         tc_cmd_o <= '0;
      end else if (tc_ack_i) begin
         tc_req_o <= 1'b0;
      end else if (tick && st_q == st_look && look_next != st_fault) begin
         tc_req_o <= 1'b1;
         tc_cmd_o.we <= look_next == st_fwd && va_q.we;
         tc_cmd_o.addr <= look_next == st_fwd ? phys
                          : {tbase_q[31:14], va_q.addr[31:20], 2'b00};
         tc_cmd_o.data <= swap32(va_q.data);
      end
   end

   // Answer capture; a new answer wins over consumption
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tc_done_q <= 1'b0;
         tc_data_q <= 32'h0;
      end else if (tc_ack_i) begin
         tc_done_q <= 1'b1;
         tc_data_q <= tc_rdata_i;
      end else if (tick && tc_done_q) begin
         tc_done_q <= 1'b0;
      end
   end

   // DSP port answer; absent while stalled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dsp_ack_o <= 1'b0;
         dsp_rdata_o <= 32'h0;
      end else begin
         dsp_ack_o <= fwd_done;
         if (fwd_done) begin
            dsp_rdata_o <= swap32(tc_data_q);
         end
      end
   end

   // Fault level, cause and address; raise wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         translation_fault_interrupt_o <= 1'b0;
         cause_q <= 3'h0;
         fault_addr_q <= 32'h0;
      end else if (fault_set) begin
         translation_fault_interrupt_o <= 1'b1;
         cause_q <= st_q == st_walk ? 3'h1 << `CAUSE_XFLT : fault_cause;
         fault_addr_q <= va_q.addr;
      end else if (iack_wr || soft_rst) begin
         translation_fault_interrupt_o <= 1'b0;
      end
   end

   // Control, idle control and divider registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= 3'h0;
         idle_q <= 2'h0;
         div_q <= `DIV_RST;
      end else if (wr_acc && wb_sel_i[0]) begin
         if (wb_adr_i == `OFS_CTRL) ctrl_q <= wb_dat_i[2:0];
         if (wb_adr_i == `OFS_IDLE) idle_q <= wb_dat_i[1:0];
         if (wb_adr_i == `OFS_CLKCTL) div_q <= wb_dat_i[1:0];
      end
   end

   // Victim and base pointers; untouched by soft reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vict_q <= 4'h0;
         base_q <= 4'h0;
      end else if (wr_acc && wb_adr_i == `OFS_LOCK && lock_ok) begin
         if (wb_sel_i[0]) vict_q <= wb_dat_i[3:0];
         if (wb_sel_i[1]) base_q <= wb_dat_i[`LOCK_BASE_LO +: 4];
      end else if (walk_tlb_wr) begin
         vict_q <= vict_q == `TLB_LAST ? base_q : vict_q + 4'h1;
      end
   end

   // Table base and staging registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tbase_q <= 32'h0;
         tag_stage_q <= 32'h0;
         xl_stage_q <= 32'h0;
      end else if (wr_acc) begin
         case (wb_adr_i)
            `OFS_TBASE_H: if (lock_ok) tbase_q[31:16] <= merge(tbase_q[31:16],
                                       wb_dat_i[15:0], wb_sel_i[1:0]);
            `OFS_TBASE_L: if (lock_ok) tbase_q[15:0] <= merge(tbase_q[15:0],
                                       wb_dat_i[15:0], wb_sel_i[1:0]);
            `OFS_TAG_H: tag_stage_q[31:16] <= merge(tag_stage_q[31:16], wb_dat_i[15:0],
                                                    wb_sel_i[1:0]);
            `OFS_TAG_L: tag_stage_q[15:0] <= merge(tag_stage_q[15:0], wb_dat_i[15:0],
                                                   wb_sel_i[1:0]);
            `OFS_XL_H: xl_stage_q[31:16] <= merge(xl_stage_q[31:16], wb_dat_i[15:0],
                                                  wb_sel_i[1:0]);
            `OFS_XL_L: xl_stage_q[15:0] <= merge(xl_stage_q[15:0], wb_dat_i[15:0],
                                                 wb_sel_i[1:0]);
            default: tbase_q <= tbase_q;
         endcase
      end
   end

   // Bus answer one cycle after the strobe, read data with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         case (wb_adr_i)
            `OFS_CTRL:    wb_dat_o <= {29'h0, ctrl_q};
            `OFS_FADDR_H: wb_dat_o <= {16'h0, fault_addr_q[31:16]};
            `OFS_FADDR_L: wb_dat_o <= {16'h0, fault_addr_q[15:0]};
            `OFS_FCAUSE:  wb_dat_o <= {29'h0, cause_q};
            `OFS_TBASE_H: wb_dat_o <= {16'h0, tbase_q[31:16]};
            `OFS_TBASE_L: wb_dat_o <= {16'h0, tbase_q[15:0]};
            `OFS_LOCK:    wb_dat_o <= {20'h0, base_q, 4'h0, vict_q};
            `OFS_TAG_H:   wb_dat_o <= {16'h0, tag_stage_q[31:16]};
            `OFS_TAG_L:   wb_dat_o <= {16'h0, tag_stage_q[15:0]};
            `OFS_XL_H:    wb_dat_o <= {16'h0, xl_stage_q[31:16]};
            `OFS_XL_L:    wb_dat_o <= {16'h0, xl_stage_q[15:0]};
            `OFS_IDLE:    wb_dat_o <= {30'h0, idle_q};
            `OFS_CLKCTL:  wb_dat_o <= {30'h0, div_q};
            default:      wb_dat_o <= 32'h0;
         endcase
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_wb_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus answer not one pulse");

   property p_lock_base;
      wr_acc && ctrl_q[`CTL_WEN] && wb_adr_i == `OFS_TBASE_L |=> $stable(tbase_q);
   endproperty
   a_lock_base: assert property (p_lock_base) else $error("base written while locked");

   property p_irq_hold;
      translation_fault_interrupt_o && !iack_wr && !soft_rst |=> translation_fault_interrupt_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("fault dropped early");

   property p_stall;
      translation_fault_interrupt_o |-> !dsp_ack_o;
   endproperty
   a_stall: assert property (p_stall) else $error("DSP answered during fault");

   property p_direct;
      $rose(tc_req_o) && !ctrl_q[`CTL_XEN] |-> tc_cmd_o.addr[31:24] == `DIRECT_HI;
   endproperty
   a_direct: assert property (p_direct) else $error("direct map left first 16M");

   sequence s_retry;
      st_q == st_fault ##[1:16] st_q == st_look;
   endsequence
   property p_retry;
      $fell(translation_fault_interrupt_o) |-> s_retry;
   endproperty
   a_retry: assert property (p_retry) else $error("no new lookup after clear");

   property p_cause;
      $rose(translation_fault_interrupt_o) |-> cause_q != 3'h0;
   endproperty
   a_cause: assert property (p_cause) else $error("fault without cause");

   property p_faddr;
      $rose(translation_fault_interrupt_o) |-> fault_addr_q == va_q.addr;
   endproperty
   a_faddr: assert property (p_faddr) else $error("wrong fault address");
endmodule // xlat_unit
